// ==== pkg/uedw_pkg.sv ====
// Shared constants and carrier types of the endpoint descriptor walker
`default_nettype none
package uedw_pkg;
    // ************************************************
    // Endpoint descriptor layout
    // ************************************************
    localparam int NODE_HI = 6, NODE_LO = 0;
    localparam int PIPE_HI = 10, PIPE_LO = 7;
    localparam int WAY_HI = 12, WAY_LO = 11;
    localparam int RATE_B = 13, BYP_B = 14, FMT_B = 15;
    localparam int PKT_HI = 26, PKT_LO = 16;
    localparam int STOP_B = 0, TOG_B = 1;
    localparam int PTR_HI = 31, PTR_LO = 4;
    localparam logic [1:0] IDX_W0 = 2'h0;
    localparam logic [1:0] IDX_W1 = 2'h1;
    localparam logic [1:0] IDX_W2 = 2'h2;
    localparam logic [1:0] IDX_W3 = 2'h3;
    localparam logic [1:0] BYTE_LO = 2'h0;
    localparam logic [1:0] ZERO_BITS = 2'h0;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [27:0] PTR_NULL = 28'h0000000;

    // ************************************************
    // Transfer descriptor fields and flow codes
    // ************************************************
    localparam int DP_HI = 20, DP_LO = 19;
    localparam int TSRC_B = 25, TVAL_B = 24;
    localparam logic [1:0] WAY_OUT = 2'h1;
    localparam logic [1:0] WAY_IN = 2'h2;

    // ************************************************
    // Register map
    // ************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LIST = 8'h04;
    localparam logic [7:0] REG_DONE = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam logic [7:0] REG_CNT = 8'h10;
    localparam int RUN_B = 0;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_DEC = 2'h3;

    // ************************************************
    // Carriers
    // ************************************************
    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_ED_RD  = 8'h02,
        ST_ED_CHK = 8'h04,
        ST_TD_RD  = 8'h08,
        ST_XFER   = 8'h10,
        ST_TD_WB  = 8'h20,
        ST_ED_WB  = 8'h40,
        ST_NEXT   = 8'h80
    } uedw_st_e;

    typedef struct packed {
        logic        valid;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } uedw_mem_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] td_addr;
        logic [6:0]  node;
        logic [3:0]  pipe;
        logic [1:0]  dir;
        logic        low_speed;
        logic        iso;
        logic [10:0] max_pkt;
        logic        toggle;
    } uedw_xfer_s;

    typedef struct packed {
        logic        run;
        logic [31:0] list;
        logic        done_clr;
    } uedw_ctl_s;

    typedef struct packed {
        logic        busy;
        logic [31:0] done;
        logic [15:0] eds;
        logic [15:0] halts;
    } uedw_stat_s;
endpackage : uedw_pkg
`default_nettype wire

// ==== hdl/uedw_axil.sv ====
// AXI4-Lite register slave of the endpoint descriptor walker
`timescale 1ns/1ns
`default_nettype none
module uedw_axil #(
    parameter int ADDR_W = 8
) (
    input  wire logic               mclk,
    input  wire logic               rst_b,
    input  wire logic [ADDR_W-1:0]  awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [ADDR_W-1:0]  araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    output uedw_pkg::uedw_ctl_s     ctl,
    input  wire uedw_pkg::uedw_stat_s stat
);
    typedef struct packed {
        logic              aw_got;
        logic [7:0]        aw_a;
        logic              w_got;
        logic [31:0]       w_d;
        logic [3:0]        w_s;
        logic              awready;
        logic              wready;
        logic              arready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        uedw_pkg::uedw_ctl_s ctl;
    } uedw_axs_s;

    uedw_axs_s st;
    uedw_axs_s next_st;

    // ************************************************
    // Write and read channels
    // ************************************************
    always_comb begin
        next_st = st;
        next_st.ctl.done_clr = 1'b0;
        if (awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.aw_a   = 8'(awaddr);
        end
        if (wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.w_d   = wdata;
            next_st.w_s   = wstrb;
        end
        if (bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        // Address and data may arrive in either order
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = uedw_pkg::RESP_OK;
            for (int b = 0; b < 4; b++) begin
                if (st.w_s[b]) begin
                    unique case (st.aw_a)
                        uedw_pkg::REG_CTRL: begin
                            if (b == 0) next_st.ctl.run = st.w_d[uedw_pkg::RUN_B];
                        end
                        uedw_pkg::REG_LIST: next_st.ctl.list[b*8 +: 8] = st.w_d[b*8 +: 8];
                        uedw_pkg::REG_DONE: next_st.ctl.done_clr = 1'b1;
                        uedw_pkg::REG_STAT, uedw_pkg::REG_CNT: ;
                        default: next_st.bresp = uedw_pkg::RESP_DEC;
                    endcase
                end
            end
        end
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready  = !next_st.w_got && !next_st.bvalid;
        if (rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = uedw_pkg::RESP_OK;
            unique case (8'(araddr))
                uedw_pkg::REG_CTRL: next_st.rdata = {31'h0, st.ctl.run};
                uedw_pkg::REG_LIST: next_st.rdata = st.ctl.list;
                uedw_pkg::REG_DONE: next_st.rdata = stat.done;
                uedw_pkg::REG_STAT: next_st.rdata = {31'h0, stat.busy};
                uedw_pkg::REG_CNT:  next_st.rdata = {stat.halts, stat.eds};
                default: begin
                    next_st.rdata = 32'h0;
                    next_st.rresp = uedw_pkg::RESP_DEC;
                end
            endcase
        end
        next_st.arready = !next_st.rvalid;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign awready = st.awready;
    assign wready  = st.wready;
    assign arready = st.arready;
    assign bvalid  = st.bvalid;
    assign bresp   = st.bresp;
    assign rvalid  = st.rvalid;
    assign rresp   = st.rresp;
    assign rdata   = st.rdata;
    assign ctl     = st.ctl;
endmodule : uedw_axil
`default_nettype wire

// ==== hdl/uedw_walker.sv ====
// Endpoint descriptor list walker with its register slave
`timescale 1ns/1ns
`default_nettype none
module uedw_walker #(
    parameter int ADDR_W = 8
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    input  wire logic [ADDR_W-1:0]    awaddr,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    input  wire logic [ADDR_W-1:0]    araddr,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready,
    output uedw_pkg::uedw_mem_s       mem_req,
    input  wire logic                 mem_ack,
    input  wire logic [31:0]          mem_rdata,
    output uedw_pkg::uedw_xfer_s      xfer_req,
    input  wire logic                 xfer_done,
    input  wire logic                 xfer_err,
    input  wire logic                 xfer_tog
);
    typedef struct packed {
        uedw_pkg::uedw_st_e  ph;
        logic [1:0]          idx;
        logic [27:0]         cur;
        logic [3:0][31:0]    ed;
        logic [31:0]         td0;
        logic [31:0]         td2;
        logic                stop;
        logic                tog;
        uedw_pkg::uedw_mem_s  mem;
        uedw_pkg::uedw_xfer_s xf;
        uedw_pkg::uedw_stat_s sta;
    } uedw_ws_s;

    uedw_ws_s            st;
    uedw_ws_s            next_st;
    uedw_pkg::uedw_ctl_s ctl;

    // ************************************************
    // Register slave
    // ************************************************
    uedw_axil #(
        .ADDR_W (ADDR_W)
    ) u_regs (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .ctl     (ctl),
        .stat    (st.sta)
    );

    // ************************************************
    // Descriptor field views
    // ************************************************
    logic        byp;
    logic        halt;
    logic        empty;
    logic [27:0] head;
    logic [27:0] link;
    logic [1:0]  way;
    logic        retire;

    assign byp    = st.ed[uedw_pkg::IDX_W0][uedw_pkg::BYP_B];
    assign halt   = st.ed[uedw_pkg::IDX_W2][uedw_pkg::STOP_B];
    assign head   = st.ed[uedw_pkg::IDX_W2][uedw_pkg::PTR_HI:uedw_pkg::PTR_LO];
    // Low nibbles of the tail and link words are software-owned
    assign empty  = st.ed[uedw_pkg::IDX_W1][uedw_pkg::PTR_HI:uedw_pkg::PTR_LO] == head;
    assign link   = st.ed[uedw_pkg::IDX_W3][uedw_pkg::PTR_HI:uedw_pkg::PTR_LO];
    assign way    = st.ed[uedw_pkg::IDX_W0][uedw_pkg::WAY_HI:uedw_pkg::WAY_LO];
    assign retire = st.ph == uedw_pkg::ST_TD_WB && mem_ack;

    // ************************************************
    // Walk sequencer
    // ************************************************
    always_comb begin
        next_st = st;
        if (st.mem.valid && mem_ack) begin
            next_st.mem.valid = 1'b0;
        end
        // Done queue retirement wins over a software clear
        if (ctl.done_clr && !retire) begin
            next_st.sta.done = 32'h0;
        end
        unique case (st.ph)
            uedw_pkg::ST_IDLE: begin
                next_st.sta.busy = 1'b0;
                if (ctl.run && ctl.list[uedw_pkg::PTR_HI:uedw_pkg::PTR_LO] != uedw_pkg::PTR_NULL) begin
                    next_st.sta.busy  = 1'b1;
                    next_st.cur       = ctl.list[uedw_pkg::PTR_HI:uedw_pkg::PTR_LO];
                    next_st.idx       = uedw_pkg::IDX_W0;
                    next_st.mem.valid = 1'b1;
                    next_st.mem.we    = 1'b0;
                    next_st.mem.addr  = {ctl.list[uedw_pkg::PTR_HI:uedw_pkg::PTR_LO],
                                         uedw_pkg::IDX_W0, uedw_pkg::BYTE_LO};
                    next_st.ph        = uedw_pkg::ST_ED_RD;
                end
            end
            uedw_pkg::ST_ED_RD: begin
                if (mem_ack) begin
                    next_st.ed[st.idx] = mem_rdata;
                    if (st.idx == uedw_pkg::IDX_W3) begin
                        next_st.ph = uedw_pkg::ST_ED_CHK;
                    end else begin
                        next_st.idx       = st.idx + 2'h1;
                        next_st.mem.valid = 1'b1;
                        next_st.mem.addr  = {st.cur, st.idx + 2'h1, uedw_pkg::BYTE_LO};
                    end
                end
            end
            uedw_pkg::ST_ED_CHK: begin
                next_st.sta.eds = st.sta.eds + 16'h1;
                if (byp || halt) begin
                    next_st.ph = uedw_pkg::ST_NEXT;
                end else if (empty) begin
                    next_st.ph = uedw_pkg::ST_NEXT;
                end else begin
                    next_st.idx       = uedw_pkg::IDX_W0;
                    next_st.mem.valid = 1'b1;
                    next_st.mem.we    = 1'b0;
                    next_st.mem.addr  = {head, uedw_pkg::IDX_W0, uedw_pkg::BYTE_LO};
                    next_st.ph        = uedw_pkg::ST_TD_RD;
                end
            end
            uedw_pkg::ST_TD_RD: begin
                if (mem_ack && st.idx == uedw_pkg::IDX_W0) begin
                    next_st.td0       = mem_rdata;
                    next_st.idx       = uedw_pkg::IDX_W2;
                    next_st.mem.valid = 1'b1;
                    next_st.mem.addr  = {head, uedw_pkg::IDX_W2, uedw_pkg::BYTE_LO};
                end else if (mem_ack) begin
                    next_st.td2           = mem_rdata;
                    next_st.xf.valid      = 1'b1;
                    next_st.xf.td_addr    = {head, uedw_pkg::NIB_ZERO};
                    next_st.xf.node       = st.ed[0][uedw_pkg::NODE_HI:uedw_pkg::NODE_LO];
                    next_st.xf.pipe       = st.ed[0][uedw_pkg::PIPE_HI:uedw_pkg::PIPE_LO];
                    next_st.xf.low_speed  = st.ed[0][uedw_pkg::RATE_B];
                    next_st.xf.iso        = st.ed[0][uedw_pkg::FMT_B];
                    next_st.xf.max_pkt    = st.ed[0][uedw_pkg::PKT_HI:uedw_pkg::PKT_LO];
                    if (way == uedw_pkg::WAY_OUT || way == uedw_pkg::WAY_IN) begin
                        next_st.xf.dir = way;
                    end else begin
                        next_st.xf.dir = st.td0[uedw_pkg::DP_HI:uedw_pkg::DP_LO];
                    end
                    if (st.td0[uedw_pkg::TSRC_B]) begin
                        next_st.xf.toggle = st.td0[uedw_pkg::TVAL_B];
                    end else begin
                        next_st.xf.toggle = st.ed[uedw_pkg::IDX_W2][uedw_pkg::TOG_B];
                    end
                    next_st.ph = uedw_pkg::ST_XFER;
                end
            end
            uedw_pkg::ST_XFER: begin
                if (xfer_done) begin
                    next_st.xf.valid = 1'b0;
                    next_st.stop     = xfer_err;
                    next_st.tog      = st.xf.iso ? st.ed[uedw_pkg::IDX_W2][uedw_pkg::TOG_B] : xfer_tog;
                    // Finished item links to the previous done head
                    next_st.mem.valid = 1'b1;
                    next_st.mem.we    = 1'b1;
                    next_st.mem.addr  = {head, uedw_pkg::IDX_W2, uedw_pkg::BYTE_LO};
                    next_st.mem.wdata = {st.sta.done[uedw_pkg::PTR_HI:uedw_pkg::PTR_LO], uedw_pkg::NIB_ZERO};
                    next_st.ph        = uedw_pkg::ST_TD_WB;
                end
            end
            uedw_pkg::ST_TD_WB: begin
                if (mem_ack) begin
                    next_st.sta.done  = {head, uedw_pkg::NIB_ZERO};
                    // Only word 2 of the endpoint is ever written
                    next_st.mem.valid = 1'b1;
                    next_st.mem.addr  = {st.cur, uedw_pkg::IDX_W2, uedw_pkg::BYTE_LO};
                    next_st.mem.wdata = {st.td2[uedw_pkg::PTR_HI:uedw_pkg::PTR_LO],
                                         uedw_pkg::ZERO_BITS, st.tog, st.stop};
                    next_st.ph        = uedw_pkg::ST_ED_WB;
                end
            end
            uedw_pkg::ST_ED_WB: begin
                if (mem_ack) begin
                    next_st.ed[uedw_pkg::IDX_W2] = st.mem.wdata;
                    if (st.stop) begin
                        next_st.sta.halts = st.sta.halts + 16'h1;
                    end
                    // One item per visit keeps the list fair
                    next_st.ph = uedw_pkg::ST_NEXT;
                end
            end
            uedw_pkg::ST_NEXT: begin
                if (link == uedw_pkg::PTR_NULL) begin
                    next_st.ph = uedw_pkg::ST_IDLE;
                end else begin
                    next_st.cur       = link;
                    next_st.idx       = uedw_pkg::IDX_W0;
                    next_st.mem.valid = 1'b1;
                    next_st.mem.we    = 1'b0;
                    next_st.mem.addr  = {link, uedw_pkg::IDX_W0, uedw_pkg::BYTE_LO};
                    next_st.ph        = uedw_pkg::ST_ED_RD;
                end
            end
            default: begin
                next_st.ph = uedw_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st    <= '0;
            st.ph <= uedw_pkg::ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign mem_req  = st.mem;
    assign xfer_req = st.xf;

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    a_skip_no_bus: assert property (
        st.ph == uedw_pkg::ST_ED_CHK && (byp || halt) |=> st.ph == uedw_pkg::ST_NEXT && !st.mem.valid)
        else $error("bypassed or stopped endpoint touched memory");
    a_empty_moves_on: assert property (
        st.ph == uedw_pkg::ST_ED_CHK && !byp && !halt && empty |=> st.ph == uedw_pkg::ST_NEXT)
        else $error("empty endpoint not skipped");
    a_pending_fetch: assert property (
        st.ph == uedw_pkg::ST_ED_CHK && !byp && !halt && !empty
        |=> st.mem.valid && !st.mem.we && st.mem.addr[31:4] == $past(head))
        else $error("pending item not fetched from queue head");
    a_head_advance: assert property (
        retire |=> st.mem.valid && st.mem.we && st.mem.addr[31:4] == st.cur
        && st.mem.wdata[31:4] == st.td2[31:4] && st.sta.done[31:4] == $past(head))
        else $error("queue head not advanced to item link");
    a_flow_way: assert property (
        st.xf.valid && (way == uedw_pkg::WAY_OUT || way == uedw_pkg::WAY_IN) |-> st.xf.dir == way)
        else $error("endpoint direction not applied");
    a_xfer_fields: assert property (
        $rose(st.xf.valid) |-> st.xf.low_speed == st.ed[0][uedw_pkg::RATE_B]
        && st.xf.iso == st.ed[0][uedw_pkg::FMT_B] && st.xf.max_pkt == st.ed[0][26:16])
        else $error("speed, format or packet limit mismatch");
    a_node_pipe: assert property (
        $rose(st.xf.valid) |-> st.xf.node == st.ed[0][6:0] && st.xf.pipe == st.ed[0][10:7])
        else $error("wrong node id or pipe");
    a_err_stops: assert property (
        st.ph == uedw_pkg::ST_XFER && xfer_done && xfer_err
        |=> st.mem.wdata[3:0] == 4'h0
        ##[1:1000] (st.ph == uedw_pkg::ST_ED_WB && st.mem.wdata[uedw_pkg::STOP_B]))
        else $error("error did not set stop bit");
    a_write_word2: assert property (
        st.mem.valid && st.mem.we |-> st.mem.addr[3:0] == 4'h8)
        else $error("write outside descriptor word 2");
    a_list_end: assert property (
        st.ph == uedw_pkg::ST_NEXT && link == uedw_pkg::PTR_NULL
        |=> st.ph == uedw_pkg::ST_IDLE ##1 st.sta.busy == (st.ph == uedw_pkg::ST_ED_RD))
        else $error("zero link did not end the walk");
endmodule : uedw_walker
`default_nettype wire

// ==== tb/uedw_mem_model.sv ====
// Memory model that holds the descriptor lists
`timescale 1ns/1ns
`default_nettype none
module uedw_mem_model (
    input  wire logic                mclk,
    input  wire uedw_pkg::uedw_mem_s req,
    output logic                     ack,
    output logic [31:0]              rdata
);
    // ****************
    // Word store, fast and slow by turns
    // ****************
    logic [31:0] mem [0:255];
    logic [1:0]  wait_n = 2'h0;
    logic        slow   = 1'b0;
    initial ack = 1'b0;
    initial rdata = 32'h0;
    always @(posedge mclk) begin
        ack <= 1'b0;
        rdata <= ~rdata; // No stale data between answers
        if (req.valid === 1'b1 && !ack) begin
            wait_n <= wait_n + 2'h1;
            if (!slow || wait_n == 2'h3) begin
                ack <= 1'b1;
                wait_n <= 2'h0;
                slow <= ~slow;
                if (req.we) begin
                    mem[req.addr[9:2]] <= req.wdata;
                end else begin
                    rdata <= mem[req.addr[9:2]];
                end
            end
        end
    end
endmodule : uedw_mem_model
`default_nettype wire

// ==== tb/usb_endpoint_descriptor_walker_tb_top.sv ====
// Self-checking bench of the endpoint descriptor walker
`timescale 1ns/1ns
`default_nettype none
module usb_endpoint_descriptor_walker_tb_top;
    // ****************
    // Stimulus and checks
    // ****************
    logic mclk = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, xfer_done = 1'b0, xfer_err = 1'b0, xfer_tog = 1'b0, mem_ack, otog, etog;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, mem_rdata, v, td0, ed0, rnd = 32'hAD78ED87;
    logic [1:0] bresp, rresp, edir;
    uedw_pkg::uedw_mem_s mem_req;
    uedw_pkg::uedw_xfer_s xfer_req;
    int n_fail = 0, checked = 0, cyc = 0, n_xfer = 0, i;
    uedw_walker uedw_walker_inst (.mclk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .mem_req, .mem_ack, .mem_rdata, .xfer_req, .xfer_done, .xfer_err, .xfer_tog);
    uedw_mem_model uedw_mem_model_inst (.mclk(mclk), .req(mem_req), .ack(mem_ack), .rdata(mem_rdata));
    always #4 mclk = ~mclk;
    function logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task finish_test;
        $display("compares=%0d mismatches=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, r);
    endtask : axw
    task axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        chk(rresp, r);
    endtask : axr
    task ed(input int b, input logic [31:0] w0, w1, w2, w3);
        uedw_mem_model_inst.mem[b] = w0;
        uedw_mem_model_inst.mem[b+1] = w1;
        uedw_mem_model_inst.mem[b+2] = w2;
        uedw_mem_model_inst.mem[b+3] = w3;
    endtask : ed
    // Cut a hang short well past the longest round
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            finish_test();
        end
    end
    // Packet engine stand-in, finishing after a varying wait
    always @(posedge mclk) begin
        xfer_done <= xfer_req.valid === 1'b1 && !xfer_done && cyc[0];
        if (xfer_req.valid === 1'b1 && xfer_done) begin
            n_xfer <= n_xfer + 1;
            chk(xfer_req.td_addr, 32'h200);
            chk({xfer_req.node, xfer_req.pipe, xfer_req.max_pkt}, {ed0[6:0], ed0[10:7], ed0[26:16]});
            chk({xfer_req.dir, xfer_req.low_speed, xfer_req.iso, xfer_req.toggle}, {edir, ed0[13], ed0[15], etog});
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        axr(uedw_pkg::REG_DONE, v, uedw_pkg::RESP_OK);
        chk(v, 32'h0);
        axr(8'h14, v, uedw_pkg::RESP_DEC);
        chk(v, 32'h0);
        axw(8'h18, 32'hFFFFFFFF, uedw_pkg::RESP_DEC);
        for (i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            ed0 = {5'h00, rnd[26:16], i == 3, 1'b0, rnd[13], i[1:0], rnd[10:0]};
            td0 = {6'h00, rnd[31:30], 3'h0, i == 0, rnd[29] && i != 0, 19'h0};
            otog = rnd[28];
            etog = td0[25] ? td0[24] : otog;
            edir = (i == 1 || i == 2) ? i[1:0] : td0[20:19];
            xfer_err <= i[0];
            xfer_tog <= (i == 3) ? ~otog : rnd[27];
            ed(32'h40, 32'h4000, 32'h300, 32'h200, 32'h110);
            ed(32'h44, 32'h0, 32'h300, 32'h201, 32'h120);
            ed(32'h48, 32'h0, 32'h300, 32'h300, 32'h130);
            ed(32'h4C, ed0, 32'h300, {28'h0000020, 2'h0, otog, 1'b0}, 32'h0);
            ed(32'h80, td0, 32'h0, 32'h300, 32'h0);
            axw(uedw_pkg::REG_LIST, 32'h100, uedw_pkg::RESP_OK);
            axw(uedw_pkg::REG_CTRL, 32'h1, uedw_pkg::RESP_OK);
            while (n_xfer == i) @(posedge mclk);
            axw(uedw_pkg::REG_CTRL, 32'h0, uedw_pkg::RESP_OK);
            do axr(uedw_pkg::REG_STAT, v, uedw_pkg::RESP_OK); while (v[0] !== 1'b0);
            chk(uedw_mem_model_inst.mem[32'h4E], {28'h0000030, 2'h0, (i == 3) ? otog : xfer_tog, i[0]});
            chk(uedw_mem_model_inst.mem[32'h42], 32'h200);
            chk(uedw_mem_model_inst.mem[32'h46], 32'h201);
            chk(uedw_mem_model_inst.mem[32'h4C], ed0);
            chk(uedw_mem_model_inst.mem[32'h82], i != 0 ? 32'h200 : 32'h0);
            chk(n_xfer, i + 1);
            axr(uedw_pkg::REG_DONE, v, uedw_pkg::RESP_OK);
            chk(v, 32'h200);
            $display("round %0d done", i);
        end
        axr(uedw_pkg::REG_CNT, v, uedw_pkg::RESP_OK);
        chk(v[31:16], 32'h2);
        finish_test();
    end
endmodule : usb_endpoint_descriptor_walker_tb_top
`default_nettype wire
